/* src/uss_top.sv */
// Purpose: push-button screen sequencer with set point, bypass, stats
// Assumes: buttons and sensor sample strobes synchronous to clk
// Notes:   temperatures are signed tenths of a degree Celsius, shown in the configured units
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01 - warmer or cooler press opens adjust screen showing value unchanged
// RULE_02 - further presses on adjust screen add or subtract one
// RULE_03 - stepping past range end wraps to the other end
// RULE_04 - next press leaves the adjust screen at once
// RULE_05 - five idle seconds on adjust screen return to temperature
// RULE_06 - each change restarts timer whose expiry zeroes the adjustment
// RULE_07 - bypass press shows override screen four seconds, retriggerable
// RULE_08 - override screen ends on next or timeout, previous screen back
// RULE_09 - enabled bypass press energises relay ten seconds, retriggerable
// RULE_10 - setting routes bypass to bypass relay or alert relay
// RULE_11 - screens ordered temp, humidity, CO2, VOC, time; disabled skipped
// RULE_12 - manual mode next press steps forward, wrapping to first
// RULE_13 - manual mode non-temperature screen reverts after thirty seconds
// RULE_14 - automatic mode steps every four seconds; next still steps
// RULE_15 - warmer, cooler, next held eight seconds enters data display
// RULE_16 - data display current temperature refreshed every second
// RULE_17 - min, max, average over 24 hours, midnight aligned with clock
// RULE_18 - with clock, min and max alternate value and time of occurrence
// RULE_19 - without clock, window starts at reset; reset clears statistics
// RULE_20 - average over all samples of current window shown as screen; code shows it as data display item USS_DD_AVG
// RULE_21 - temperatures shown in Fahrenheit or Celsius per units setting
// RULE_22 - buttons debounced and counted once per press edge
module uss_top
   import uss_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = SEC_CYC,
   parameter int unsigned DEB_CYCLES = DEBOUNCE_CYC,
   parameter int unsigned WIN_SEC    = WINDOW_S,
   parameter int          TW         = 12
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              btn_warmer,
   input  wire logic              btn_cooler,
   input  wire logic              btn_bypass,
   input  wire logic              btn_next,
   input  wire logic [4:0]        screen_en,
   input  wire logic              auto_scroll,
   input  wire logic signed [3:0] adj_min,
   input  wire logic signed [3:0] adj_max,
   input  wire logic [15:0]       adj_reset_s,
   input  wire logic              bypass_en,
   input  wire logic              bypass_to_alert,
   input  wire logic              rtc_present,
   input  wire logic              rtc_midnight,
   input  wire logic [10:0]       rtc_minute,
   input  wire logic              units_c,
   input  wire logic              temp_valid,
   input  wire logic signed [TW-1:0] temp_c,
   output logic [2:0]             screen,
   output logic [1:0]             dd_item,
   output logic                   dd_show_time,
   output logic signed [3:0]      adj_value,
   output logic signed [TW+1:0]   disp_temp,
   output logic [10:0]            disp_minute,
   output logic                   bypass_relay,
   output logic                   alert_relay
);

   // ------------------------------------------------------------
   // buttons
   // ------------------------------------------------------------
   logic [3:0] raw;
   logic [3:0] lvl;
   logic [3:0] prs;
   assign raw = {btn_next, btn_bypass, btn_cooler, btn_warmer};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_btn
         uss_debounce #(.STABLE_CYC(DEB_CYCLES)) u_db
         (
            .clk       (clk),
            .rst       (rst),
            .btn_raw   (raw[gi]),
            .btn_level (lvl[gi]),
            .btn_press (prs[gi])
         ); // RULE_22
      end
   endgenerate

   wire logic combo  = lvl[0] && lvl[1] && lvl[3];
   wire logic p_warm = prs[0] && !combo;
   wire logic p_cool = prs[1] && !combo;
   wire logic p_byp  = prs[2];
   wire logic p_next = prs[3] && !combo;
   wire logic any_p  = |prs;

   // ------------------------------------------------------------
   // one second tick
   // ------------------------------------------------------------
   logic [31:0] div_q;
   wire  logic  tick = (div_q == SEC_CYCLES - 1);
   always_ff @(posedge clk)
   begin
      if (rst)
         div_q <= 32'h0;
      else
         div_q <= tick ? 32'h0 : div_q + 32'h1;
   end

   // ------------------------------------------------------------
   // next enabled main screen
   // ------------------------------------------------------------
   logic [2:0] main_q;
   logic [2:0] nxt_main;
   always_comb
   begin
      nxt_main = 3'h0;
      for (int k = NSCR; k >= 1; k--)
      begin
         int idx;
         idx = (int'(main_q) + k) % NSCR;
         if (screen_en[idx])
            nxt_main = 3'(idx); // RULE_11 RULE_12
      end
   end
   wire logic main_first = !screen_en[main_q] ||
                           (main_q == 3'(USS_SCR_TEMP));

   // ------------------------------------------------------------
   // screen state
   // ------------------------------------------------------------
   uss_screen_t scr_q;
   uss_screen_t byp_ret_q;
   logic [5:0]  sec_q;
   logic [3:0]  hold_q;

   wire logic in_adj  = (scr_q == USS_SCR_ADJ);
   wire logic in_byp  = (scr_q == USS_SCR_BYP);
   wire logic in_data = (scr_q == USS_SCR_DATA);
   wire logic in_main = !in_adj && !in_byp && !in_data;
   wire logic data_go = combo && tick && (hold_q == 4'(DATA_HOLD_S - 1));

   wire logic adj_idle  = in_adj && tick && (sec_q == 6'(ADJ_IDLE_S - 1));
   wire logic byp_done  = in_byp && tick && (sec_q == 6'(BYP_SCREEN_S - 1));
   wire logic auto_step = in_main && auto_scroll && tick &&
                          (sec_q == 6'(AUTO_STEP_S - 1));
   wire logic man_rev   = in_main && !auto_scroll && !main_first && tick &&
                          (sec_q == 6'(MAN_REVERT_S - 1));

   always_ff @(posedge clk)
   begin
      if (rst)
         hold_q <= 4'h0;
      else if (!combo || data_go)
         hold_q <= 4'h0;
      else if (tick)
         hold_q <= hold_q + 4'h1; // RULE_15
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         scr_q     <= USS_SCR_TEMP;
         main_q    <= 3'(USS_SCR_TEMP);
         byp_ret_q <= USS_SCR_TEMP;
         sec_q     <= 6'h0;
      end
      else if (data_go)
      begin
         scr_q <= USS_SCR_DATA; // RULE_15
         sec_q <= 6'h0;
      end
      else if (p_byp && !in_data)
      begin
         if (!in_byp)
            byp_ret_q <= scr_q;
         scr_q <= USS_SCR_BYP; // RULE_07
         sec_q <= 6'h0;
      end
      else if (in_byp && (p_next || byp_done))
      begin
         scr_q <= byp_ret_q; // RULE_08
         sec_q <= 6'h0;
      end
      else if ((p_warm || p_cool) && !in_data)
      begin
         scr_q <= USS_SCR_ADJ; // RULE_01
         sec_q <= 6'h0;
      end
      else if (in_adj && (p_next || adj_idle))
      begin
         scr_q  <= USS_SCR_TEMP; // RULE_04 RULE_05
         main_q <= 3'(USS_SCR_TEMP);
         sec_q  <= 6'h0;
      end
      else if (in_main && (p_next || auto_step))
      begin
         main_q <= nxt_main; // RULE_12 RULE_14
         scr_q  <= uss_screen_t'(nxt_main);
         sec_q  <= 6'h0;
      end
      else if (man_rev)
      begin
         main_q <= 3'(USS_SCR_TEMP); // RULE_13
         scr_q  <= USS_SCR_TEMP;
         sec_q  <= 6'h0;
      end
      else if (in_data && p_next)
      begin
         scr_q  <= uss_screen_t'(main_q);
         sec_q  <= 6'h0;
      end
      else if (any_p && in_adj)
         sec_q <= 6'h0;
      else if (tick && sec_q != 6'h3F)
         sec_q <= sec_q + 6'h1;
   end

   // ------------------------------------------------------------
   // set point adjustment and its reset timer
   // ------------------------------------------------------------
   logic signed [3:0] adj_q;
   logic [15:0]       art_q;
   wire logic inc = in_adj && p_warm;
   wire logic dec = in_adj && p_cool;
   wire logic signed [3:0] adj_up = (adj_q >= adj_max) ? adj_min : adj_q + 4'sh1;
   wire logic signed [3:0] adj_dn = (adj_q <= adj_min) ? adj_max : adj_q - 4'sh1;
   wire logic art_exp = tick && (art_q == 16'h1);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         adj_q <= 4'sh0;
         art_q <= 16'h0;
      end
      else if (inc || dec)
      begin
         adj_q <= inc ? adj_up : adj_dn; // RULE_02 RULE_03
         art_q <= adj_reset_s; // RULE_06
      end
      else if (art_exp)
      begin
         adj_q <= 4'sh0; // RULE_06
         art_q <= 16'h0;
      end
      else if (tick && art_q != 16'h0)
         art_q <= art_q - 16'h1;
   end

   // ------------------------------------------------------------
   // bypass relay
   // ------------------------------------------------------------
   logic [3:0] rly_q;
   logic       byp_rly_q;
   logic       alm_rly_q;
   wire logic  rly_on = (rly_q != 4'h0);
   always_ff @(posedge clk)
   begin
      if (rst)
         rly_q <= 4'h0;
      else if (p_byp && bypass_en)
         rly_q <= 4'(BYP_RELAY_S); // RULE_09
      else if (tick && rly_on)
         rly_q <= rly_q - 4'h1;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         byp_rly_q <= 1'b0;
         alm_rly_q <= 1'b0;
      end
      else
      begin
         byp_rly_q <= rly_on && !bypass_to_alert; // RULE_10
         alm_rly_q <= rly_on && bypass_to_alert; // RULE_10
      end
   end

   // ------------------------------------------------------------
   // temperature statistics
   // ------------------------------------------------------------
   logic signed [TW-1:0] min_q;
   logic signed [TW-1:0] max_q;
   logic signed [TW-1:0] cur_q;
   logic [10:0]          min_t_q;
   logic [10:0]          max_t_q;
   logic signed [39:0]   sum_q;
   logic [27:0]          n_q;
   logic [16:0]          win_q;
   wire logic win_new = rtc_present ? rtc_midnight
                        : (tick && win_q == 17'(WIN_SEC - 1)); // RULE_17 RULE_19
   wire logic first = (n_q == 28'h0);

   always_ff @(posedge clk)
   begin
      if (rst || win_new || rtc_present)
         win_q <= 17'h0;
      else if (tick)
         win_q <= win_q + 17'h1;
   end

   always_ff @(posedge clk)
   begin
      if (rst || win_new)
      begin
         min_q <= '0; // RULE_19
         max_q <= '0;
         sum_q <= 40'sh0;
         n_q   <= 28'h0;
      end
      else if (temp_valid)
      begin
         if (first || temp_c < min_q)
            min_q <= temp_c; // RULE_17
         if (first || temp_c > max_q)
            max_q <= temp_c;
         sum_q <= sum_q + 40'(temp_c); // RULE_20
         n_q   <= n_q + 28'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         min_t_q <= 11'h0;
         max_t_q <= 11'h0;
      end
      else if (temp_valid && !win_new)
      begin
         if (first || temp_c < min_q)
            min_t_q <= rtc_minute; // RULE_18
         if (first || temp_c > max_q)
            max_t_q <= rtc_minute;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         cur_q <= '0;
      else if (tick)
         cur_q <= temp_c; // RULE_16
   end

   // single-cycle divide on the tick: average refreshed once a second is plenty
   logic signed [39:0] avg_q;
   always_ff @(posedge clk)
   begin
      if (rst || first)
         avg_q <= 40'sh0;
      else if (tick)
         avg_q <= sum_q / $signed({12'h0, n_q}); // RULE_20
   end

   // ------------------------------------------------------------
   // data display items
   // ------------------------------------------------------------
   uss_dd_t    dd_q;
   logic       alt_q;
   logic [1:0] alt_cnt_q;
   always_ff @(posedge clk)
   begin
      if (rst || !in_data)
         dd_q <= USS_DD_CUR;
      else if (p_warm)
         unique case (dd_q)
            USS_DD_CUR: dd_q <= USS_DD_MIN;
            USS_DD_MIN: dd_q <= USS_DD_MAX;
            USS_DD_MAX: dd_q <= USS_DD_AVG;
            USS_DD_AVG: dd_q <= USS_DD_CUR;
         endcase
   end
   always_ff @(posedge clk)
   begin
      if (rst || !rtc_present || p_warm)
      begin
         alt_q     <= 1'b0;
         alt_cnt_q <= 2'h0;
      end
      else if (tick)
      begin
         alt_cnt_q <= (alt_cnt_q == 2'(ALT_S - 1)) ? 2'h0 : alt_cnt_q + 2'h1;
         if (alt_cnt_q == 2'(ALT_S - 1))
            alt_q <= !alt_q; // RULE_18
      end
   end

   logic signed [TW-1:0] sel_t;
   always_comb
   begin
      unique case (dd_q)
         USS_DD_MIN: sel_t = min_q;
         USS_DD_MAX: sel_t = max_q;
         USS_DD_AVG: sel_t = avg_q[TW-1:0];
         default:    sel_t = cur_q;
      endcase
   end
   // tenths: F = C * 9 / 5 + 320
   wire logic signed [TW+4:0] f_ful = (TW+5)'(sel_t) * 5'sd9 / 5'sd5 + 10'sd320;

   logic signed [TW+1:0] disp_q;
   logic [10:0]          dmin_q;
   logic                 dtim_q;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         disp_q <= '0;
         dmin_q <= 11'h0;
         dtim_q <= 1'b0;
      end
      else
      begin
         disp_q <= units_c ? (TW+2)'(sel_t) : f_ful[TW+1:0]; // RULE_21
         dmin_q <= (dd_q == USS_DD_MAX) ? max_t_q : min_t_q;
         dtim_q <= in_data && alt_q &&
                   (dd_q == USS_DD_MIN || dd_q == USS_DD_MAX); // RULE_18
      end
   end

   assign screen       = scr_q;
   assign dd_item      = dd_q;
   assign dd_show_time = dtim_q;
   assign adj_value    = adj_q; // RULE_01
   assign disp_temp    = disp_q;
   assign disp_minute  = dmin_q;
   assign bypass_relay = byp_rly_q;
   assign alert_relay  = alm_rly_q;

endmodule
`default_nettype wire

/* src/uss_pkg.sv */
// Purpose: constants for the user-interface screen sequencer
// Assumes: 50 MHz system clock
// Notes:   times in their own unit, cycle counts derived from the rate
package uss_pkg;

   localparam int unsigned CLK_HZ        = 50000000;
   localparam int unsigned ADJ_IDLE_S    = 5;
   localparam int unsigned BYP_SCREEN_S  = 4;
   localparam int unsigned BYP_RELAY_S   = 10;
   localparam int unsigned MAN_REVERT_S  = 30;
   localparam int unsigned AUTO_STEP_S   = 4;
   localparam int unsigned DATA_HOLD_S   = 8;
   localparam int unsigned REFRESH_S     = 1;
   localparam int unsigned ALT_S         = 2;
   localparam int unsigned WINDOW_S      = 86400;
   localparam int unsigned DEBOUNCE_US   = 20000;

   localparam int unsigned SEC_CYC      = CLK_HZ;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);

   localparam int unsigned NSCR = 5;

   // screen codes, display order
   typedef enum logic [2:0]
   {
      USS_SCR_TEMP  = 3'h0,
      USS_SCR_HUM   = 3'h1,
      USS_SCR_CO2   = 3'h2,
      USS_SCR_VOC   = 3'h3,
      USS_SCR_TIME  = 3'h4,
      USS_SCR_ADJ   = 3'h5,
      USS_SCR_BYP   = 3'h6,
      USS_SCR_DATA  = 3'h7
   } uss_screen_t;

   typedef enum logic [1:0]
   {
      USS_DD_CUR = 2'h0,
      USS_DD_MIN = 2'h1,
      USS_DD_MAX = 2'h3,
      USS_DD_AVG = 2'h2
   } uss_dd_t;

   localparam logic [4:0] SCR_EN_RST = 5'h01;

endpackage

/* src/uss_debounce.sv */
// Purpose: debounce one push button and pulse once per press
// Assumes: input synchronous to clk
// Notes:   held button gives a single pulse
`timescale 1ns/1ps
`default_nettype none
module uss_debounce
   import uss_pkg::*;
#(
   parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic btn_raw,
   output logic      btn_level,
   output logic      btn_press
);

   logic [31:0] cnt_q;
   logic        lvl_q;
   logic        prs_q;
   wire  logic  differs = (btn_raw != lvl_q);
   wire  logic  settled = (cnt_q >= STABLE_CYC - 1);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_q <= 32'h0;
         lvl_q <= 1'b0;
         prs_q <= 1'b0;
      end
      else
      begin
         cnt_q <= (differs && !settled) ? cnt_q + 32'h1 : 32'h0;
         prs_q <= differs && settled && btn_raw;
         if (differs && settled)
            lvl_q <= btn_raw;
      end
   end

   assign btn_level = lvl_q;
   assign btn_press = prs_q;

endmodule
`default_nettype wire

/* tb/uss_top_sva.sv */
// Purpose: port checker for uss_top
// Assumes: bench shortens second and debounce counts
// Notes:   bound to every uss_top instance
`timescale 1ns/1ps
`default_nettype none
module uss_top_chk
   import uss_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = SEC_CYC,
   parameter int unsigned DEB_CYCLES = DEBOUNCE_CYC
)
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              btn_warmer,
   input wire logic              btn_cooler,
   input wire logic              btn_bypass,
   input wire logic              btn_next,
   input wire logic signed [3:0] adj_min,
   input wire logic signed [3:0] adj_max,
   input wire logic              bypass_en,
   input wire logic              bypass_to_alert,
   input wire logic [2:0]        screen,
   input wire logic signed [3:0] adj_value,
   input wire logic              bypass_relay,
   input wire logic              alert_relay
);
   // ----
   // hold counters
   // ----
   logic [31:0] on_q;
   logic [31:0] all_q;
   logic [31:0] nx_q;
   wire         rly = bypass_relay | alert_relay;

   always_ff @(posedge clk)
   begin
      on_q  <= (rst | ~rly) ? 32'h0 : on_q + 32'h1;
      all_q <= (rst | ~(btn_warmer & btn_cooler & btn_next)) ? 32'h0
               : all_q + 32'h1;
      nx_q  <= (rst | ~btn_next) ? 32'h0 : nx_q + 32'h1;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_all_held;
      btn_warmer && btn_cooler && btn_next;
   endsequence

   a_adj_open: assert property (
      $rose(screen == USS_SCR_ADJ) |-> adj_value == $past(adj_value))
      else $error("adjust screen opened with changed value");
   a_adj_range: assert property (
      adj_value >= adj_min && adj_value <= adj_max)
      else $error("adjustment outside its range");
   a_adj_change: assert property (
      $changed(adj_value) |->
      $past(screen) == USS_SCR_ADJ || adj_value == 4'sh0)
      else $error("adjustment changed off adjust screen");
   a_next_exit: assert property (
      screen == USS_SCR_ADJ && !btn_warmer && !btn_cooler |->
      nx_q <= DEB_CYCLES + 6)
      else $error("next press did not leave adjust screen");
   a_byp_screen: assert property (
      $rose(screen == USS_SCR_BYP) |-> btn_bypass)
      else $error("override screen without bypass press");
   a_relay_cause: assert property (
      $rose(rly) |-> bypass_en && btn_bypass)
      else $error("relay energised without enabled press");
   a_relay_span: assert property (
      $fell(rly) |-> on_q >= 9 * SEC_CYCLES)
      else $error("relay pulse too short");
   a_relay_route: assert property (
      $rose(rly) |-> alert_relay == bypass_to_alert)
      else $error("relay routed wrongly");
   a_relay_excl: assert property (
      !(bypass_relay && alert_relay))
      else $error("both relays energised");
   a_data_entry: assert property (
      $rose(screen == USS_SCR_DATA) |->
      s_all_held ##0 all_q >= 7 * SEC_CYCLES)
      else $error("data display entered without long hold");
endmodule
bind uss_top uss_top_chk #(.SEC_CYCLES(SEC_CYCLES),
   .DEB_CYCLES(DEB_CYCLES)) u_uss_top_chk (.clk(clk), .rst(rst),
   .btn_warmer(btn_warmer), .btn_cooler(btn_cooler),
   .btn_bypass(btn_bypass), .btn_next(btn_next), .adj_min(adj_min),
   .adj_max(adj_max), .bypass_en(bypass_en),
   .bypass_to_alert(bypass_to_alert), .screen(screen),
   .adj_value(adj_value), .bypass_relay(bypass_relay),
   .alert_relay(alert_relay));
`default_nettype wire

/* tb/uss_keypad.sv */
// Purpose: keypad model facing uss_top
// Assumes: key vector set by the bench after a falling edge
// Notes:   contacts modelled clean; bounce left to the debouncer
`timescale 1ns/1ps
`default_nettype none
module uss_keypad
(
   input  wire logic [3:0] keys,
   output logic            btn_warmer,
   output logic            btn_cooler,
   output logic            btn_bypass,
   output logic            btn_next
);
   // a held key stays high, so one press is one long level
   assign {btn_next, btn_bypass, btn_cooler, btn_warmer} = keys;
endmodule
`default_nettype wire

/* tb/ui_screen_sequencer_test.sv */
// Purpose: self-checking bench for uss_top
// Assumes: one second shortened to 20 cycles
// Notes:   rows hold {keys, screen, adjustment}
`timescale 1ns/1ps
`default_nettype none
module ui_screen_sequencer_test
   import uss_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, auto_scroll = 1'b0, bypass_en = 1'b1;
   logic bypass_to_alert = 1'b0, units_c = 1'b1, temp_valid = 1'b0;
   logic rtc_present = 1'b0, rtc_midnight = 1'b0;
   logic [10:0] rtc_minute = 11'h000, disp_minute;
   logic signed [3:0] adj_min = 4'shD, adj_max = 4'sh3;
   logic [3:0] keys = 4'h0;
   logic [4:0] screen_en = 5'h1F;
   logic [15:0] adj_reset_s = 16'h0064;
   logic signed [11:0] temp_c = 12'sh0FA;
   logic btn_warmer, btn_cooler, btn_bypass, btn_next, dd_show_time;
   logic bypass_relay, alert_relay;
   logic [2:0] screen;
   logic [1:0] dd_item;
   logic signed [3:0] adj_value;
   logic signed [13:0] disp_temp;
   int fail_count = 0, compares = 0;
   logic [11:0] rows [14] = '{12'h150, 12'h151, 12'h152, 12'h153,
      12'h15D, 12'h253, 12'h803, 12'h813, 12'h823, 12'h833, 12'h843,
      12'h803, 12'h463, 12'h803};

   uss_keypad u_uss_keypad (.keys, .btn_warmer, .btn_cooler,
      .btn_bypass, .btn_next);
   uss_top #(.SEC_CYCLES(20), .DEB_CYCLES(2), .WIN_SEC(2000), .TW(12))
   u_uss_top (.clk, .rst, .btn_warmer, .btn_cooler, .btn_bypass,
      .btn_next, .screen_en, .auto_scroll, .adj_min,
      .adj_max, .adj_reset_s, .bypass_en, .bypass_to_alert,
      .rtc_present, .rtc_midnight, .rtc_minute,
      .units_c, .temp_valid, .temp_c, .screen, .dd_item, .dd_show_time,
      .adj_value, .disp_temp, .disp_minute, .bypass_relay,
      .alert_relay);

   // ----
   // helpers
   // ----
   initial forever #10 clk = ~clk;

   task automatic check(input string what, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic press(input logic [3:0] k, input int hold);
      keys = k;
      repeat (hold) @(negedge clk);
      keys = 4'h0;
      repeat (8) @(negedge clk);
   endtask

   task automatic wait_s(input int n);
      repeat (n * 20) @(negedge clk);
   endtask

   task automatic wrap_up;
      if (fail_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----
   // sequence
   // ----
   initial
   begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      temp_valid = 1'b1;
      foreach (rows[i])
      begin
         press(rows[i][11:8], 8);
         check("screen", 16'(screen), 16'(rows[i][6:4]));
         check("adjust", {12'h000, adj_value}, {12'h000, rows[i][3:0]});
      end
      check("bypass relay", 16'(bypass_relay), 16'h0001);
      check("alert relay", 16'(alert_relay), 16'h0000);
      wait_s(12);
      check("bypass relay", 16'(bypass_relay), 16'h0000);
      bypass_to_alert = 1'b1;
      press(4'h4, 8);
      check("alert relay", 16'(alert_relay), 16'h0001);
      wait_s(5);
      check("screen", 16'(screen), 16'(USS_SCR_TEMP));
      press(4'h4, 8);
      repeat (130) @(negedge clk);
      check("alert relay", 16'(alert_relay), 16'h0001);
      wait_s(12);
      bypass_to_alert = 1'b0;
      adj_reset_s = 16'h0003;
      press(4'h1, 8);
      press(4'h1, 8);
      repeat (130) @(negedge clk);
      check("screen", 16'(screen), 16'(USS_SCR_TEMP));
      check("adjust", {12'h000, adj_value}, 16'h0000);
      press(4'h8, 8);
      wait_s(31);
      check("screen", 16'(screen), 16'(USS_SCR_TEMP));
      screen_en = 5'h15;
      press(4'h8, 8);
      check("screen", 16'(screen), 16'(USS_SCR_CO2));
      press(4'h8, 8);
      press(4'h8, 8);
      check("screen", 16'(screen), 16'(USS_SCR_TEMP));
      auto_scroll = 1'b1;
      repeat (100) @(negedge clk);
      check("screen", 16'(screen), 16'(USS_SCR_CO2));
      auto_scroll = 1'b0;
      screen_en = 5'h1F;
      temp_c = 12'sh12C;
      press(4'hB, 180);
      check("screen", 16'(screen), 16'(USS_SCR_DATA));
      wait_s(2);
      check("temperature", disp_temp, 16'h012C);
      units_c = 1'b0;
      wait_s(2);
      check("temperature", disp_temp, 16'h035C);
      press(4'h1, 8);
      wait_s(2);
      check("item", 16'(dd_item), 16'(USS_DD_MIN));
      check("minimum", disp_temp, 16'h0302);
      check("time shown", 16'(dd_show_time), 16'h0000);
      rtc_present = 1'b1;
      rtc_minute = 11'h05A;
      wait_s(3);
      check("time shown", 16'(dd_show_time), 16'h0001);
      rtc_midnight = 1'b1;
      @(negedge clk);
      rtc_midnight = 1'b0;
      wait_s(1);
      check("minimum", disp_temp, 16'h035C);
      check("minute", 16'(disp_minute), 16'h005A);
      rtc_present = 1'b0;
      press(4'h8, 8);
      check("data left", 16'(screen == USS_SCR_DATA), 16'h0000);
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("reset", {screen, adj_value, dd_item, bypass_relay}, 16'h0);
      wrap_up();
   end

   // cut a hang short well past the expected span
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
